/* hdl/blk_req_pkg.sv */
package blk_req_pkg;

    // Geometry of the request format
    localparam int SECTOR_SHIFT = 9;
    localparam int SECTOR_BYTES = 512;
    localparam int SENSE_BYTES = 96;
    localparam int TAG_W = 4;

    // Request type codes and the barrier flag position
    localparam logic [31:0] T_READ = 32'h0000_0000;
    localparam logic [31:0] T_WRITE = 32'h0000_0001;
    localparam logic [31:0] T_SCSI = 32'h0000_0002;
    localparam logic [31:0] T_SCSI_OUT = 32'h0000_0003;
    localparam logic [31:0] T_FLUSH = 32'h0000_0004;
    localparam logic [31:0] T_FLUSH_LEGACY = 32'h0000_0005;
    localparam int BARRIER_BIT = 31;

    // Final status byte values
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_IOERR = 8'h01;
    localparam logic [7:0] ST_UNSUPP = 8'h02;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CAP_LO = 8'h04;
    localparam logic [7:0] REG_CAP_HI = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_DONE_COUNT = 8'h10;

    // Control field positions and reset values
    localparam int CTRL_RO = 0;
    localparam int CTRL_BARRIER = 1;
    localparam int CTRL_SCSI = 2;
    localparam int CTRL_LEGACY = 3;
    localparam int CTRL_GUEST_BE = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam logic [63:0] CAP_RESET = 64'h0;

    // Status register field positions
    localparam int STAT_BARRIER = 8;
    localparam int STAT_BE_BUSY = 9;
    localparam int STAT_CMP_BUSY = 10;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_FLUSH, OP_SCSI} be_op_e;

    // Request as posted by the driver, memory byte order
    typedef struct packed {
        logic [31:0] req_type;
        logic [31:0] reserved;
        logic [63:0] sector;
        logic [31:0] data_len;
        logic [15:0] cmd_len;
        logic [TAG_W-1:0] tag;
    } req_s;

    // Command towards the storage backend
    typedef struct packed {
        be_op_e op;
        logic [63:0] addr;
        logic [31:0] len;
        logic [15:0] cmd_len;
        logic [31:0] prio;
        logic [TAG_W-1:0] tag;
    } be_cmd_s;

    // Backend completion, any order
    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic err;
        logic [31:0] xfer;
        logic [7:0] sense_len;
    } be_done_s;

    // Completion towards the driver
    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [7:0] status;
        logic [31:0] sense_len;
        logic [31:0] residual;
    } cmp_s;

endpackage

/* hdl/blk_req_proc.sv */
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module blk_req_proc #(
    parameter int MAX_OUT = 8
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    // AXI4-Lite write
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Requests from the driver queue
    input wire blk_req_pkg::req_s I_REQ,
    input wire logic I_REQ_VALID,
    output logic O_REQ_READY,
    // Backend commands
    output blk_req_pkg::be_cmd_s O_BE_CMD,
    output logic O_BE_VALID,
    input wire logic I_BE_READY,
    // Backend completions
    input wire blk_req_pkg::be_done_s I_DONE,
    input wire logic I_DONE_VALID,
    output logic O_DONE_READY,
    // Completions to the driver
    output blk_req_pkg::cmp_s O_CMP,
    output logic O_CMP_VALID,
    input wire logic I_CMP_READY
);

    localparam int TAGS = 2 ** blk_req_pkg::TAG_W;
    localparam int CNT_W = $clog2(MAX_OUT + 1);

    // Tag space bounds the outstanding window
    if (MAX_OUT < 1 || MAX_OUT > TAGS) begin : max_out_bad
        $error("MAX_OUT must be within 1 and the tag space");
    end

    // Byte reversal for guest-native fields
    function automatic logic [63:0] bswap64(input logic [63:0] v);
        logic [63:0] r;
        r = 64'h0;
        for (int i = 0; i < 8; i++) begin
            r[8*i +: 8] = v[8*(7-i) +: 8];
        end
        return r;
    endfunction

    function automatic logic [31:0] bswap32(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    // Registers
    logic [blk_req_pkg::CTRL_W-1:0] ctrl_r;
    logic [63:0] cap_r;
    logic [31:0] done_cnt_r;
    logic [CNT_W-1:0] out_cnt_r;
    logic barrier_hold_r;
    logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [3:0] wstrb_r;
    logic [31:0] wdata_r, rdata_r;
    logic [1:0] bresp_r, rresp_r;
    blk_req_pkg::be_cmd_s be_cmd_r;
    logic be_valid_r;
    blk_req_pkg::cmp_s cmp_r;
    logic cmp_valid_r;
    logic [31:0] tbl_len_r [TAGS];
    logic tbl_scsi_r [TAGS];

    // Feature switches
    wire ro_en = ctrl_r[blk_req_pkg::CTRL_RO];
    wire barrier_en = ctrl_r[blk_req_pkg::CTRL_BARRIER];
    wire scsi_en = ctrl_r[blk_req_pkg::CTRL_SCSI];
    wire legacy_en = ctrl_r[blk_req_pkg::CTRL_LEGACY];
    wire swap_en = legacy_en & ctrl_r[blk_req_pkg::CTRL_GUEST_BE];

    // Header fields in host order
    wire [31:0] req_type = swap_en ? bswap32(I_REQ.req_type) : I_REQ.req_type;
    wire [31:0] req_rsvd = swap_en ? bswap32(I_REQ.reserved) : I_REQ.reserved;
    wire [63:0] req_sector = swap_en ? bswap64(I_REQ.sector) : I_REQ.sector;
    wire is_barrier = barrier_en & req_type[blk_req_pkg::BARRIER_BIT];
    wire [31:0] base_type = {1'b0, req_type[30:0]};

    // Type decode
    wire is_read = base_type == blk_req_pkg::T_READ;
    wire is_write = base_type == blk_req_pkg::T_WRITE;
    wire is_flush = (base_type == blk_req_pkg::T_FLUSH) |
                    (legacy_en & (base_type == blk_req_pkg::T_FLUSH_LEGACY));
    wire is_scsi = scsi_en & ((base_type == blk_req_pkg::T_SCSI) |
                              (base_type == blk_req_pkg::T_SCSI_OUT));
    wire is_rw = is_read | is_write;
    wire known = is_rw | is_flush | is_scsi;

    // Length and extent checks
    wire [63:0] end_sector = req_sector + {41'h0, I_REQ.data_len[31:blk_req_pkg::SECTOR_SHIFT]};
    wire len_bad = is_rw & (I_REQ.data_len[blk_req_pkg::SECTOR_SHIFT-1:0] != 9'h000);
    wire over_cap = is_rw & (end_sector > cap_r);
    wire cmd_bad = is_scsi & (I_REQ.cmd_len == 16'h0000);
    wire ro_hit = ro_en & is_write;
    wire req_err = len_bad | over_cap | cmd_bad | ro_hit;
    wire to_backend = known & ~req_err;
    wire [7:0] rej_status = known ? blk_req_pkg::ST_IOERR : blk_req_pkg::ST_UNSUPP;

    // Issue and completion handshakes
    wire be_free = ~be_valid_r | I_BE_READY;
    wire cmp_free = ~cmp_valid_r | I_CMP_READY;
    wire room = out_cnt_r < CNT_W'(MAX_OUT);
    wire barrier_block = barrier_hold_r | (is_barrier & (out_cnt_r != '0));
    wire req_ready = ~barrier_block & (to_backend ? (be_free & room) : (cmp_free & ~I_DONE_VALID));
    wire accept = I_REQ_VALID & req_ready;
    wire be_load = accept & to_backend;
    wire rej_load = accept & ~to_backend;
    wire done_take = I_DONE_VALID & cmp_free;
    wire [CNT_W-1:0] out_cnt_nxt = out_cnt_r + CNT_W'(be_load) - CNT_W'(done_take);

    // Backend command build
    blk_req_pkg::be_op_e op_sel;
    always_comb begin
        if (is_write) begin
            op_sel = blk_req_pkg::OP_WRITE;
        end else if (is_flush) begin
            op_sel = blk_req_pkg::OP_FLUSH;
        end else if (is_scsi) begin
            op_sel = blk_req_pkg::OP_SCSI;
        end else begin
            op_sel = blk_req_pkg::OP_READ; // Barrier keeps its own type
        end
    end
    wire [63:0] rw_addr = {req_sector[54:0], 9'h000};
    blk_req_pkg::be_cmd_s be_cmd_nxt;
    assign be_cmd_nxt.op = op_sel;
    assign be_cmd_nxt.addr = is_rw ? rw_addr : 64'h0;
    assign be_cmd_nxt.len = is_flush ? 32'h0 : I_REQ.data_len;
    assign be_cmd_nxt.cmd_len = is_scsi ? I_REQ.cmd_len : 16'h0000;
    assign be_cmd_nxt.prio = legacy_en ? req_rsvd : 32'h0;
    assign be_cmd_nxt.tag = I_REQ.tag;

    // Completion build from backend result or local refusal
    wire [31:0] done_len = tbl_len_r[I_DONE.tag];
    wire done_scsi = tbl_scsi_r[I_DONE.tag];
    wire [7:0] sense_cap = (I_DONE.sense_len > 8'(blk_req_pkg::SENSE_BYTES)) ?
                           8'(blk_req_pkg::SENSE_BYTES) : I_DONE.sense_len;
    wire [31:0] sense_raw = done_scsi ? {24'h0, sense_cap} : 32'h0;
    wire [31:0] resid_raw = done_scsi ? (done_len - I_DONE.xfer) : 32'h0;
    blk_req_pkg::cmp_s cmp_nxt;
    assign cmp_nxt.tag = done_take ? I_DONE.tag : I_REQ.tag;
    assign cmp_nxt.status = done_take ? (I_DONE.err ? blk_req_pkg::ST_IOERR : blk_req_pkg::ST_OK) : rej_status;
    assign cmp_nxt.sense_len = done_take ? (swap_en ? bswap32(sense_raw) : sense_raw) : 32'h0;
    assign cmp_nxt.residual = done_take ? (swap_en ? bswap32(resid_raw) : resid_raw) : 32'h0;

    // Backend command stage
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            be_valid_r <= 1'b0;
            be_cmd_r <= '0;
        end else if (be_free) begin
            be_valid_r <= be_load;
            be_cmd_r <= be_load ? be_cmd_nxt : be_cmd_r;
        end
    end

    // Per-tag memory of what a completion needs
    always_ff @(posedge I_CLK_SYS) begin
        if (be_load) begin
            tbl_len_r[I_REQ.tag] <= I_REQ.data_len;
            tbl_scsi_r[I_REQ.tag] <= is_scsi;
        end
    end

    // Completion stage, status after backend finished or on local refusal
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            cmp_valid_r <= 1'b0;
            cmp_r <= '0;
        end else if (cmp_free) begin
            cmp_valid_r <= done_take | rej_load;
            cmp_r <= (done_take | rej_load) ? cmp_nxt : cmp_r;
        end
    end

    // Outstanding count and barrier hold
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            out_cnt_r <= '0;
            barrier_hold_r <= 1'b0;
        end else begin
            out_cnt_r <= out_cnt_nxt;
            barrier_hold_r <= (be_load & is_barrier) | (barrier_hold_r & (out_cnt_nxt != '0));
        end
    end

    // Completed request counter
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            done_cnt_r <= 32'h0;
        end else if (cmp_valid_r & I_CMP_READY) begin
            done_cnt_r <= done_cnt_r + 32'h1;
        end
    end

    // Register bus decode
    wire aw_take = I_AWVALID & ~aw_have_r & ~bvalid_r;
    wire w_take = I_WVALID & ~w_have_r & ~bvalid_r;
    wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}}; // Strobes held with data
    wire wr_ctrl = wr_go & (awaddr_r == blk_req_pkg::REG_CTRL);
    wire wr_cap_lo = wr_go & (awaddr_r == blk_req_pkg::REG_CAP_LO);
    wire wr_cap_hi = wr_go & (awaddr_r == blk_req_pkg::REG_CAP_HI);
    wire wr_hit = wr_ctrl | wr_cap_lo | wr_cap_hi;
    wire [31:0] ctrl_word = {{(32 - blk_req_pkg::CTRL_W){1'b0}}, ctrl_r};
    wire [31:0] ctrl_new = (ctrl_word & ~wmask) | (wdata_r & wmask);
    wire [31:0] cap_lo_new = (cap_r[31:0] & ~wmask) | (wdata_r & wmask);
    wire [31:0] cap_hi_new = (cap_r[63:32] & ~wmask) | (wdata_r & wmask);
    wire ar_take = I_ARVALID & ~rvalid_r;
    wire [31:0] status_word = {21'h0, cmp_valid_r, be_valid_r, barrier_hold_r, 8'(out_cnt_r)};
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (I_ARADDR)
            blk_req_pkg::REG_CTRL: rd_word = ctrl_word;
            blk_req_pkg::REG_CAP_LO: rd_word = cap_r[31:0];
            blk_req_pkg::REG_CAP_HI: rd_word = cap_r[63:32];
            blk_req_pkg::REG_STATUS: rd_word = status_word;
            blk_req_pkg::REG_DONE_COUNT: rd_word = done_cnt_r;
            default: begin
                rd_word = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write address and data capture
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else begin
            aw_have_r <= aw_take | (aw_have_r & ~wr_go);
            w_have_r <= w_take | (w_have_r & ~wr_go);
            awaddr_r <= aw_take ? I_AWADDR : awaddr_r;
            wdata_r <= w_take ? I_WDATA : wdata_r;
            wstrb_r <= w_take ? I_WSTRB : wstrb_r;
        end
    end

    // Register writes and write response
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            ctrl_r <= blk_req_pkg::CTRL_RESET;
            cap_r <= blk_req_pkg::CAP_RESET;
            bvalid_r <= 1'b0;
            bresp_r <= blk_req_pkg::RESP_OKAY;
        end else begin
            ctrl_r <= wr_ctrl ? ctrl_new[blk_req_pkg::CTRL_W-1:0] : ctrl_r;
            cap_r <= {wr_cap_hi ? cap_hi_new : cap_r[63:32], wr_cap_lo ? cap_lo_new : cap_r[31:0]};
            bvalid_r <= wr_go | (bvalid_r & ~I_BREADY);
            bresp_r <= wr_go ? (wr_hit ? blk_req_pkg::RESP_OKAY : blk_req_pkg::RESP_SLVERR) : bresp_r;
        end
    end

    // Read response
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= blk_req_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= ar_take | (rvalid_r & ~I_RREADY);
            rdata_r <= ar_take ? rd_word : rdata_r;
            rresp_r <= ar_take ? (rd_hit ? blk_req_pkg::RESP_OKAY : blk_req_pkg::RESP_SLVERR) : rresp_r;
        end
    end

    // Port drive
    assign O_AWREADY = ~aw_have_r & ~bvalid_r;
    assign O_WREADY = ~w_have_r & ~bvalid_r;
    assign O_BVALID = bvalid_r;
    assign O_BRESP = bresp_r;
    assign O_ARREADY = ~rvalid_r;
    assign O_RVALID = rvalid_r;
    assign O_RDATA = rdata_r;
    assign O_RRESP = rresp_r;
    assign O_REQ_READY = req_ready;
    assign O_BE_CMD = be_cmd_r;
    assign O_BE_VALID = be_valid_r;
    assign O_DONE_READY = cmp_free;
    assign O_CMP = cmp_r;
    assign O_CMP_VALID = cmp_valid_r;

    // Checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    chk_ro_write_err: assert property (accept & ro_hit |-> ~be_load ##1 cmp_valid_r &&
        cmp_r.status == blk_req_pkg::ST_IOERR) else $error("read-only write not failed");
    chk_unknown_unsupp: assert property (accept & ~known |=> cmp_valid_r &&
        cmp_r.status == blk_req_pkg::ST_UNSUPP) else $error("unknown type not unsupported");
    chk_rw_addr_scale: assert property (be_load & is_rw |=>
        be_cmd_r.addr == ($past(req_sector) << 9)) else $error("byte address not sector times 512");
    chk_flush_addr_zero: assert property (be_valid_r && (be_cmd_r.op == blk_req_pkg::OP_FLUSH ||
        be_cmd_r.op == blk_req_pkg::OP_SCSI) |-> be_cmd_r.addr == 64'h0) else $error("sector used");
    chk_barrier_drain: assert property (accept & is_barrier |-> out_cnt_r == '0)
        else $error("barrier started with requests pending");
    chk_barrier_hold: assert property (barrier_hold_r |-> ~accept)
        else $error("request started behind barrier");
    chk_legacy_flush: assert property (accept & legacy_en & to_backend &
        (base_type == blk_req_pkg::T_FLUSH_LEGACY) |=> be_cmd_r.op == blk_req_pkg::OP_FLUSH)
        else $error("legacy flush synonym not flushed");
    chk_barrier_no_flush: assert property (be_load & is_barrier & is_read |=>
        be_cmd_r.op == blk_req_pkg::OP_READ) else $error("barrier turned into flush");
    chk_residual_calc: assert property (done_take & done_scsi & ~swap_en |=>
        cmp_r.residual == $past(done_len) - $past(I_DONE.xfer)) else $error("residual wrong");
    chk_sense_bound: assert property (cmp_valid_r & ~swap_en |->
        cmp_r.sense_len <= 32'(blk_req_pkg::SENSE_BYTES)) else $error("sense count above buffer");
    chk_status_cause: assert property ($rose(cmp_valid_r) |-> $past(done_take | rej_load))
        else $error("status without finished transfer");

    // Completion codes, decode and window checks
    chk_scsi_same_op: assert property (be_load & is_scsi |=>
        be_cmd_r.op == blk_req_pkg::OP_SCSI) else $error("packet command types decoded apart");
    chk_dev_err_status: assert property (done_take & I_DONE.err |=> cmp_valid_r &&
        cmp_r.status == blk_req_pkg::ST_IOERR) else $error("backend error not reported");
    chk_dev_ok_status: assert property (done_take & ~I_DONE.err |=> cmp_valid_r &&
        cmp_r.status == blk_req_pkg::ST_OK) else $error("backend success not reported");
    chk_flush_no_data: assert property (be_load & is_flush |=> be_cmd_r.len == 32'h0)
        else $error("flush carries data length");
    chk_out_cnt_bound: assert property (out_cnt_r <= CNT_W'(MAX_OUT))
        else $error("outstanding window overrun");

endmodule

/* test/blk_backend_model.sv */
`timescale 1ns/1ps
// Storage backend: one command at a time, answered after a set delay
module blk_backend_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Command side
    input wire blk_req_pkg::be_cmd_s i_cmd,
    input wire logic i_valid,
    output logic o_ready,
    // Completion side
    output blk_req_pkg::be_done_s o_done,
    output logic o_done_valid,
    input wire logic i_done_ready,
    input wire logic [3:0] i_dly
);
    blk_req_pkg::be_cmd_s cmd;

    // Accept, wait, then report exactly one completion per command
    initial begin
        o_ready = 1'b0;
        o_done_valid = 1'b0;
        o_done = '0;
        forever begin
            @(posedge i_clk);
            if (i_valid && !i_reset) begin
                o_ready <= 1'b1;
                @(posedge i_clk);
                cmd = i_cmd;
                o_ready <= 1'b0;
                repeat (i_dly) @(posedge i_clk);
                o_done.tag <= cmd.tag;
                o_done.err <= (cmd.len == 32'h600); // Backend fault on three-sector transfers
                // Short transfer on packet commands leaves a residual
                o_done.xfer <= (cmd.op == blk_req_pkg::OP_SCSI) ? cmd.len - 32'h200 : cmd.len;
                o_done.sense_len <= 8'h64; // More than the sense buffer holds
                o_done_valid <= 1'b1;
                do @(posedge i_clk); while (!i_done_ready);
                o_done_valid <= 1'b0;
                o_done <= ~o_done; // Released payload is stale
            end
        end
    end
endmodule

/* test/block_request_processor_tb.sv */
`timescale 1ns/1ps
// Bench for the request processor
module block_request_processor_tb;
    logic clk, rst, awv, wv, bready, arv, rready, req_valid, be_ready, done_valid, done_ready;
    logic be_valid, cmp_valid, req_ready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rsv, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] dly, tg;
    logic [31:0] sc [2];
    blk_req_pkg::req_s req;
    blk_req_pkg::be_cmd_s be_cmd, be_last;
    blk_req_pkg::be_done_s done;
    blk_req_pkg::cmp_s cmp_w, cmp;
    int errors, compares, n_be, cyc;

    blk_req_proc uut (.I_CLK_SYS(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_REQ(req), .I_REQ_VALID(req_valid),
        .O_REQ_READY(req_ready), .O_BE_CMD(be_cmd), .O_BE_VALID(be_valid), .I_BE_READY(be_ready),
        .I_DONE(done), .I_DONE_VALID(done_valid), .O_DONE_READY(done_ready), .O_CMP(cmp_w),
        .O_CMP_VALID(cmp_valid), .I_CMP_READY(1'b1));
    blk_backend_model be (.i_clk(clk), .i_reset(rst), .i_cmd(be_cmd), .i_valid(be_valid), .o_ready(be_ready),
        .o_done(done), .o_done_valid(done_valid), .i_done_ready(done_ready), .i_dly(dly));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Backend command log and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (be_valid && be_ready) begin
            be_last <= be_cmd;
            n_be <= n_be + 1;
        end
        if (cyc == 6000) begin
            errors = errors + 1;
            summarize();
        end
    end

    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] exp);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= dat;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (!aw_d && awready) begin
                aw_d = 1'b1;
                awv <= 1'b0;
            end
            if (!w_d && wready) begin
                w_d = 1'b1;
                wv <= 1'b0;
            end
        end while (!(aw_d && w_d));
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        check("bresp", bresp, exp);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arready);
        arv <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        dat = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // One request from post to completion, counting backend commands
    task automatic rq(input logic [31:0] typ, input logic [63:0] sec, input logic [31:0] len,
        input logic [15:0] cl, input logic [7:0] st, input int nb);
        int n0;
        n0 = n_be;
        @(posedge clk);
        req <= {typ, rsv, sec, len, cl, tg}; // Header, data size, command length, tag in order
        req_valid <= 1'b1;
        do @(posedge clk); while (!req_ready);
        req_valid <= 1'b0;
        do @(posedge clk); while (!cmp_valid);
        cmp = cmp_w; // Sense and residual lengths are read by the packet tests
        check("status", cmp.status, st);
        check("tag", cmp.tag, req.tag);
        check("commands", n_be - n0, nb);
        tg <= tg + 4'h1;
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {awv, wv, bready, arv, rready, req_valid} = '0;
        awaddr = '0; araddr = '0; wdata = '0; req = '0; rsv = '0; tg = '0; dly = 4'h2;
        errors = 0; compares = 0; n_be = 0; cyc = 0;
        sc = '{blk_req_pkg::T_SCSI, blk_req_pkg::T_SCSI_OUT};
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        axi_rd(blk_req_pkg::REG_CTRL, d, r);
        check("ctrl_reset", d, 0);
        rq(blk_req_pkg::T_WRITE, 64'h3, 32'h400, 0, blk_req_pkg::ST_IOERR, 0);
        axi_wr(blk_req_pkg::REG_CAP_LO, 32'h10, blk_req_pkg::RESP_OKAY);
        axi_wr(8'h14, 32'h0, blk_req_pkg::RESP_SLVERR);
        axi_rd(8'h14, d, r);
        check("unmapped", {r, d}, {blk_req_pkg::RESP_SLVERR, 32'h0});
        rq(blk_req_pkg::T_WRITE, 64'h3, 32'h400, 0, blk_req_pkg::ST_OK, 1);
        check("wr_cmd", {be_last.op, be_last.addr, be_last.len}, {blk_req_pkg::OP_WRITE, 64'h600, 32'h400});
        dly = 4'hB;
        rq(blk_req_pkg::T_READ, 64'hF, 32'h200, 0, blk_req_pkg::ST_OK, 1);
        check("rd_cmd", {be_last.op, be_last.addr}, {blk_req_pkg::OP_READ, 64'h1E00});
        rq(blk_req_pkg::T_READ, 64'h0, 32'h3E8, 0, blk_req_pkg::ST_IOERR, 0);
        rq(blk_req_pkg::T_FLUSH, 64'h0, 32'h0, 0, blk_req_pkg::ST_OK, 1);
        check("fl_op", be_last.op, blk_req_pkg::OP_FLUSH);
        rq(blk_req_pkg::T_FLUSH_LEGACY, 64'h0, 32'h0, 0, blk_req_pkg::ST_UNSUPP, 0);
        rq(blk_req_pkg::T_SCSI, 64'h0, 32'h400, 6, blk_req_pkg::ST_UNSUPP, 0);
        // Legacy with packet commands enabled
        axi_wr(blk_req_pkg::REG_CTRL, 32'h0C, blk_req_pkg::RESP_OKAY);
        rsv = 32'h7;
        rq(blk_req_pkg::T_FLUSH_LEGACY, 64'h0, 32'h0, 0, blk_req_pkg::ST_OK, 1);
        check("leg_fl", {be_last.op, be_last.prio}, {blk_req_pkg::OP_FLUSH, 32'h7});
        rsv = 32'h0;
        dly = 4'h1;
        for (int i = 0; i < 2; i++) begin
            rq(sc[i], 64'h0, 32'h400, 16'h6, blk_req_pkg::ST_OK, 1);
            check("pc_cmd", {be_last.op, be_last.cmd_len}, {blk_req_pkg::OP_SCSI, 16'h6});
            check("pc_sense", cmp.sense_len, 32'h60);
            check("pc_resid", cmp.residual, 32'h200);
        end
        // Guest big-endian fields under legacy
        axi_wr(blk_req_pkg::REG_CTRL, 32'h18, blk_req_pkg::RESP_OKAY);
        rq(32'h0100_0000, 64'h0300_0000_0000_0000, 32'h200, 0, blk_req_pkg::ST_OK, 1);
        check("be_addr", {be_last.op, be_last.addr}, {blk_req_pkg::OP_WRITE, 64'h600});
        // Barrier orders only
        axi_wr(blk_req_pkg::REG_CTRL, 32'h02, blk_req_pkg::RESP_OKAY);
        dly = 4'h8;
        fork
            rq(32'h8000_0001, 64'h1, 32'h200, 0, blk_req_pkg::ST_OK, 1);
            begin
                repeat (4) @(posedge clk);
                axi_rd(blk_req_pkg::REG_STATUS, d, r);
                check("bar_stat", d[10:0], 11'h101);
            end
        join
        check("bar_op", be_last.op, blk_req_pkg::OP_WRITE);
        // Read-only medium
        axi_wr(blk_req_pkg::REG_CTRL, 32'h01, blk_req_pkg::RESP_OKAY);
        rq(blk_req_pkg::T_WRITE, 64'h2, 32'h200, 0, blk_req_pkg::ST_IOERR, 0);
        rq(blk_req_pkg::T_READ, 64'h2, 32'h200, 0, blk_req_pkg::ST_OK, 1);
        rq(blk_req_pkg::T_READ, 64'h4, 32'h600, 0, blk_req_pkg::ST_IOERR, 1);
        axi_rd(blk_req_pkg::REG_DONE_COUNT, d, r);
        check("done_count", d, 32'h0000_000F);
        summarize();
    end
endmodule
